// ==== src/vectored_irq_router.v ====
// Vectored interrupt router for 56 level requests and two processor targets.
// Assumes synchronous request inputs and configuration held by software ports.
// What this block does
// [RULE_01] Level requests, per input programmable polarity.
// [RULE_02] Software request per input acts like hardware.
// [RULE_03] Raw request state readable before masking.
// [RULE_04] Per input priority register, levels to 15.
// [RULE_05] 56 inputs, each with own target.
// [RULE_06] Target 0 fast input, 1 standard input.
// [RULE_07] Per target threshold compared against request priority.
// [RULE_08] Priority zero never raises any interrupt.
// [RULE_09] Level 15 most urgent, level 1 least.
// [RULE_10] Vector identifies winning request per target.
// [RULE_11] Higher priority preempts lower via raised threshold.
// [RULE_12] All logic runs on router branch clock.
// [RULE_13] Output asserted only when priority exceeds threshold.
// [RULE_14] Ties go to lowest input index.
`timescale 1ns/1ps
`include "irq_router_consts.vh"
module vectored_irq_router (
    input  wire                       irq_router_branch_clock,
    input  wire                       nrst,
    input  wire [`NUM_REQ-1:0]        req_in,
    input  wire [`NUM_REQ-1:0]        req_invert,
    input  wire [`NUM_REQ-1:0]        sw_req,
    input  wire [`NUM_REQ*`PRIO_W-1:0] req_prio,
    input  wire [`NUM_REQ-1:0]        req_target,
    input  wire [`PRIO_W-1:0]         fast_threshold,
    input  wire [`PRIO_W-1:0]         std_threshold,
    output reg  [`NUM_REQ-1:0]        raw_state,
    output reg                        fast_interrupt_request,
    output reg                        std_interrupt_request,
    output reg  [`VEC_W-1:0]          fast_vector,
    output reg  [`VEC_W-1:0]          std_vector,
    output reg  [`PRIO_W-1:0]         fast_prio,
    output reg  [`PRIO_W-1:0]         std_prio
);
    // Request after polarity and software merge, one bit per input.
    wire [`NUM_REQ-1:0]               active;

    // Requests allowed to compete on each target.
    wire [`NUM_REQ-1:0]               eligible_fast;
    wire [`NUM_REQ-1:0]               eligible_std;

    // Running winner along the request chain; slot 0 holds no winner.
    wire [(`NUM_REQ+1)*`PRIO_W-1:0]   chain_fast_prio;
    wire [(`NUM_REQ+1)*`VEC_W-1:0]    chain_fast_vector;
    wire [(`NUM_REQ+1)*`PRIO_W-1:0]   chain_std_prio;
    wire [(`NUM_REQ+1)*`VEC_W-1:0]    chain_std_vector;

    wire [`NUM_REQ-1:0]               next_raw_state;
    wire [`PRIO_W-1:0]                next_fast_prio;
    wire [`PRIO_W-1:0]                next_std_prio;
    wire [`VEC_W-1:0]                 next_fast_vector;
    wire [`VEC_W-1:0]                 next_std_vector;
    wire                              next_fast_interrupt_request;
    wire                              next_std_interrupt_request;

    assign chain_fast_prio[`PRIO_W-1:0]  = `PRIO_MASKED;
    assign chain_fast_vector[`VEC_W-1:0] = `VEC_NONE;
    assign chain_std_prio[`PRIO_W-1:0]   = `PRIO_MASKED;
    assign chain_std_vector[`VEC_W-1:0]  = `VEC_NONE;

    genvar g;
    generate
        for (g = 0; g < `NUM_REQ; g = g + 1) begin : gen_req
            localparam integer VEC_NUM = g + `VEC_OFFSET;

            wire [`PRIO_W-1:0] prio;
            wire [`VEC_W-1:0]  vector;
            wire               routed_fast;
            wire               prio_live;
            wire               take_fast;
            wire               take_std;
            wire [`PRIO_W-1:0] prev_fast_prio;
            wire [`VEC_W-1:0]  prev_fast_vector;
            wire [`PRIO_W-1:0] prev_std_prio;
            wire [`VEC_W-1:0]  prev_std_vector;

            // Polarity applied, then software request merged in.
            assign active[g] = (req_in[g] ^ req_invert[g]) | sw_req[g]; // [RULE_01] [RULE_02]

            assign prio = req_prio[g*`PRIO_W +: `PRIO_W]; // [RULE_04] [RULE_05]

            // Vector is the input index plus one, so zero means no winner.
            assign vector = VEC_NUM[`VEC_W-1:0]; // [RULE_10]

            assign routed_fast = (req_target[g] == `TARGET_FAST); // [RULE_06]

            assign prio_live = (prio != `PRIO_MASKED); // [RULE_08]

            assign eligible_fast[g] = active[g]
                                    & prio_live
                                    & routed_fast
                                    & (prio > fast_threshold); // [RULE_07] [RULE_13]

            assign eligible_std[g] = active[g]
                                   & prio_live
                                   & ~routed_fast
                                   & (prio > std_threshold); // [RULE_07] [RULE_13]

            assign prev_fast_prio   = chain_fast_prio[g*`PRIO_W +: `PRIO_W];
            assign prev_fast_vector = chain_fast_vector[g*`VEC_W +: `VEC_W];
            assign prev_std_prio    = chain_std_prio[g*`PRIO_W +: `PRIO_W];
            assign prev_std_vector  = chain_std_vector[g*`VEC_W +: `VEC_W];

            // Strictly greater keeps the lower index when priorities tie.
            assign take_fast = eligible_fast[g]
                             & (prio > prev_fast_prio); // [RULE_09] [RULE_14]

            assign take_std = eligible_std[g]
                            & (prio > prev_std_prio); // [RULE_09] [RULE_14]

            assign chain_fast_prio[(g+1)*`PRIO_W +: `PRIO_W] = take_fast
                                                             ? prio
                                                             : prev_fast_prio;

            assign chain_fast_vector[(g+1)*`VEC_W +: `VEC_W] = take_fast
                                                             ? vector
                                                             : prev_fast_vector;

            assign chain_std_prio[(g+1)*`PRIO_W +: `PRIO_W] = take_std
                                                            ? prio
                                                            : prev_std_prio;

            assign chain_std_vector[(g+1)*`VEC_W +: `VEC_W] = take_std
                                                            ? vector
                                                            : prev_std_vector;
        end
    endgenerate

    assign next_raw_state = active; // [RULE_03]

    assign next_fast_prio   = chain_fast_prio[`NUM_REQ*`PRIO_W +: `PRIO_W];
    assign next_fast_vector = chain_fast_vector[`NUM_REQ*`VEC_W +: `VEC_W];
    assign next_std_prio    = chain_std_prio[`NUM_REQ*`PRIO_W +: `PRIO_W];
    assign next_std_vector  = chain_std_vector[`NUM_REQ*`VEC_W +: `VEC_W];

    // A raised threshold lets only higher priorities interrupt a running service.
    assign next_fast_interrupt_request = (next_fast_prio != `PRIO_MASKED); // [RULE_11] [RULE_13]
    assign next_std_interrupt_request  = (next_std_prio != `PRIO_MASKED); // [RULE_11] [RULE_13]

    always @(posedge irq_router_branch_clock) begin // [RULE_12]
        if (!nrst) begin
            raw_state <= `REQ_RESET;
        end else begin
            raw_state <= next_raw_state; // [RULE_03]
        end
    end

    always @(posedge irq_router_branch_clock) begin // [RULE_12]
        if (!nrst) begin
            fast_interrupt_request <= `IRQ_IDLE;
        end else begin
            fast_interrupt_request <= next_fast_interrupt_request; // [RULE_13]
        end
    end

    always @(posedge irq_router_branch_clock) begin // [RULE_12]
        if (!nrst) begin
            std_interrupt_request <= `IRQ_IDLE;
        end else begin
            std_interrupt_request <= next_std_interrupt_request; // [RULE_13]
        end
    end

    always @(posedge irq_router_branch_clock) begin // [RULE_12]
        if (!nrst) begin
            fast_vector <= `VEC_NONE;
        end else begin
            fast_vector <= next_fast_vector; // [RULE_10]
        end
    end

    always @(posedge irq_router_branch_clock) begin // [RULE_12]
        if (!nrst) begin
            std_vector <= `VEC_NONE;
        end else begin
            std_vector <= next_std_vector; // [RULE_10]
        end
    end

    always @(posedge irq_router_branch_clock) begin // [RULE_12]
        if (!nrst) begin
            fast_prio <= `PRIO_MASKED;
        end else begin
            fast_prio <= next_fast_prio; // [RULE_09]
        end
    end

    always @(posedge irq_router_branch_clock) begin // [RULE_12]
        if (!nrst) begin
            std_prio <= `PRIO_MASKED;
        end else begin
            std_prio <= next_std_prio; // [RULE_09]
        end
    end

endmodule

// ==== src/irq_router_consts.vh ====
// Constants for the vectored interrupt router.
// Assumes inclusion by the router module only.
`ifndef IRQ_ROUTER_CONSTS_VH
`define IRQ_ROUTER_CONSTS_VH
`define NUM_REQ        56
`define IDX_W          6
`define PRIO_W         4
`define PRIO_MASKED    4'h0
`define TARGET_FAST    1'b0
`define TARGET_STD     1'b1
`define VEC_NONE       7'h00
`define VEC_W          7
`define VEC_OFFSET     1
`define IRQ_IDLE       1'b0
`define REQ_RESET      56'h00000000000000
`define PRIO_RESET     224'h0
`define THR_RESET      4'h0
`endif

// ==== sim/router_chk.sv ====
// Checker on the router ports.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/1ps
module router_chk(input wire irq_router_branch_clock, nrst, fast_interrupt_request, std_interrupt_request,
    input wire [55:0] req_in, req_invert, sw_req, raw_state, input wire [6:0] fast_vector, std_vector,
    input wire [3:0] fast_threshold, std_threshold, fast_prio, std_prio);
    reg live;
    always @(posedge irq_router_branch_clock) live <= nrst;
    default clocking @(posedge irq_router_branch_clock); endclocking
    default disable iff (!nrst);
    raw_seen_a: assert property(live|->raw_state==$past(req_in^req_invert|sw_req))else $error("raw");
    fast_level_a: assert property(live|->fast_interrupt_request==(fast_prio>$past(fast_threshold)))
        else $error("fq");
    std_level_a: assert property(live|->std_interrupt_request==(std_prio>$past(std_threshold)))
        else $error("sq");
    fast_vec_a: assert property(fast_interrupt_request==(fast_vector!=0))else $error("fv");
    std_vec_a: assert property(std_interrupt_request==(std_vector!=0))else $error("sv");
    fast_range_a: assert property(fast_vector<=56)else $error("fr");
    std_range_a: assert property(std_vector<=56)else $error("sr");
    quiet_idle_a: assert property(raw_state==0|->!fast_interrupt_request&&!std_interrupt_request)
        else $error("q");
    cover property(fast_interrupt_request);
    cover property(std_interrupt_request);
    cover property(fast_interrupt_request&&std_interrupt_request);
    cover property(std_interrupt_request ##1 std_interrupt_request&&std_prio>$past(std_prio));
endmodule
bind vectored_irq_router router_chk router_chk_inst(.*);

// ==== sim/irq_cpu_model.sv ====
// Core model that raises the standard threshold while it services.
// Assumes the router's standard outputs feed it.
`timescale 1ns/1ps
module irq_cpu_model(input wire clock, done, irq, input wire [3:0] prio, output reg [3:0] level);
    always @(posedge clock) level <= done ? 4'h0 : irq ? prio : level;
endmodule

// ==== sim/vectored_irq_router_test.sv ====
// Random bench for the router with a core model on the standard target.
// Assumes outputs follow inputs one cycle later.
`timescale 1ns/1ps
module vectored_irq_router_test;
    reg clock, nrst, done;
    reg [55:0] ri, iv, sw, tg, rw;
    reg [223:0] pr;
    reg [3:0] ft, st;
    wire fq, sq;
    wire [55:0] raw;
    wire [6:0] fv, sv;
    wire [3:0] fp, sp, sth;
    integer n_mismatch = 0, n_tests = 0, n;
    vectored_irq_router vectored_irq_router_inst(.irq_router_branch_clock(clock), .nrst(nrst), .req_in(ri),
        .req_invert(iv), .sw_req(sw), .req_prio(pr), .req_target(tg), .fast_threshold(ft), .std_threshold(sth),
        .raw_state(raw), .fast_interrupt_request(fq), .std_interrupt_request(sq), .fast_vector(fv),
        .std_vector(sv), .fast_prio(fp), .std_prio(sp));
    irq_cpu_model irq_cpu_model_inst(.clock(clock), .done(done), .irq(sq), .prio(sp), .level(sth));
    initial begin clock = 0; forever #10 clock = ~clock; end
    initial begin #50000; n_mismatch++; wrap_up; end
    task check(input [63:0] seen, exp); begin n_tests++; if (seen !== exp) begin n_mismatch++;
        $display("ERROR %0t %h %h", $time, seen, exp); end end endtask
    function [10:0] win(input t, input [3:0] th); integer i; begin win = 0;
        for (i = 0; i < 56; i++) if (rw[i] && tg[i] == t && pr[4*i+:4] > th && pr[4*i+:4] > win[3:0])
            win = {i[6:0] + 7'h1, pr[4*i+:4]}; end endfunction
    task wrap_up; begin $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish; end endtask
    initial begin
        nrst = 0; done = 1; {ri, iv, sw, tg, pr, ft} = 0; n = $urandom(95982);
        repeat (10) @(negedge clock);
        nrst = 1;
        for (n = 0; n < 400; n++) begin
            ri = {$urandom, $urandom} & {$urandom, $urandom}; iv = n[0] ? {$urandom, $urandom} : 0;
            sw = n % 5 ? 0 : {$urandom, $urandom} & {$urandom, $urandom}; tg = {$urandom, $urandom};
            pr = n % 8 ? {7{$urandom}} : {56{4'h9}}; ft = $urandom; done = $urandom % 4 == 0;
            st = sth; rw = ri ^ iv | sw;
            @(negedge clock);
            check(raw, rw);
            check({fq, fv, fp}, {|win(0, ft), win(0, ft)});
            check({sq, sv, sp}, {|win(1, st), win(1, st)});
        end
        wrap_up;
    end
endmodule
